// ==== hw/chlc_regs.sv ====
// charger limit configuration registers with write hold-off
`timescale 1ns/100ps
`include "chlc_defines.svh"

module chlc_regs
#(
	parameter int HOLDOFF_CYCLES = `CHLC_HOLDOFF_CYCLES
)
(
	input  wire logic        clock_in,
	input  wire logic        resetn_in,
	input  wire logic        clk_en_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	input  wire logic [6:0]  float_voltage_code_in,
	input  wire logic [12:0] battery_mv_in,
	output logic             holdoff_active_out,
	output logic      [4:0]  input_current_ceiling_out,
	output logic      [11:0] input_current_ceiling_ma_out,
	output logic      [1:0]  auto_limit_voltage_threshold_out,
	output logic      [1:0]  boost_output_voltage_sel_out,
	output logic      [1:0]  boost_undervoltage_threshold_out,
	output logic      [1:0]  overcharge_margin_sel_out,
	output logic      [12:0] overcharge_trip_mv_out,
	output logic             overcharge_detect_out
);

	initial
	begin
		if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES > 65535)
			$error("chlc_regs: HOLDOFF_CYCLES out of range");
	end

	// ==========================================
	// conversions
	function automatic logic [11:0] ceiling_ma(input logic [4:0] code);
		logic [4:0] lim;
		lim = (code > `CHLC_CEIL_MAX_CODE) ? `CHLC_CEIL_MAX_CODE : code;
		ceiling_ma = 12'(`CHLC_CEIL_BASE_MA + 12'(lim) * `CHLC_CEIL_STEP_MA);
	endfunction

	function automatic logic [12:0] margin_mv(input logic [1:0] code);
		margin_mv = 13'(`CHLC_MARGIN_MAX_MV - 13'(code) * `CHLC_MARGIN_STEP_MV);
	endfunction

	// ==========================================
	// register state
	logic [4:0]  ceil_reg;
	logic [1:0]  auto_th_reg;
	logic [1:0]  boost_v_reg;
	logic [1:0]  boost_uv_reg;
	logic [1:0]  margin_reg;
	logic [7:0]  rdata;
	logic [4:0]  next_ceil_reg;
	logic [1:0]  next_auto_th_reg;
	logic [1:0]  next_boost_v_reg;
	logic [1:0]  next_boost_uv_reg;
	logic [1:0]  next_margin_reg;
	logic [7:0]  next_rdata;

	always_comb
	begin
		next_ceil_reg     = ceil_reg;
		next_auto_th_reg  = auto_th_reg;
		next_boost_v_reg  = boost_v_reg;
		next_boost_uv_reg = boost_uv_reg;
		next_margin_reg   = margin_reg;
		next_rdata        = rdata;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				`CHLC_ADDR_INPUT_LIMIT:
				begin
					next_ceil_reg    = reg_wdata_in[`CHLC_CEIL_MSB:`CHLC_CEIL_LSB];
					next_auto_th_reg = reg_wdata_in[`CHLC_AUTO_TH_MSB:`CHLC_AUTO_TH_LSB];
				end
				`CHLC_ADDR_BOOST_OUTPUT:
				begin
					next_boost_v_reg  = reg_wdata_in[`CHLC_BOOST_V_MSB:`CHLC_BOOST_V_LSB];
					next_boost_uv_reg = reg_wdata_in[`CHLC_BOOST_UV_MSB:`CHLC_BOOST_UV_LSB];
				end
				`CHLC_ADDR_OVERCHARGE:
					next_margin_reg = reg_wdata_in[`CHLC_MARGIN_MSB:`CHLC_MARGIN_LSB];
				default:
					next_margin_reg = margin_reg;
			endcase
		end
		if (reg_rd_in)
		begin
			next_rdata = 8'h00;
			case (reg_addr_in)
				`CHLC_ADDR_INPUT_LIMIT:
				begin
					next_rdata[`CHLC_CEIL_MSB:`CHLC_CEIL_LSB]       = ceil_reg;
					next_rdata[`CHLC_AUTO_TH_MSB:`CHLC_AUTO_TH_LSB] = auto_th_reg;
				end
				`CHLC_ADDR_BOOST_OUTPUT:
				begin
					next_rdata[`CHLC_BOOST_V_MSB:`CHLC_BOOST_V_LSB]   = boost_v_reg;
					next_rdata[`CHLC_BOOST_UV_MSB:`CHLC_BOOST_UV_LSB] = boost_uv_reg;
				end
				`CHLC_ADDR_OVERCHARGE:
					next_rdata[`CHLC_MARGIN_MSB:`CHLC_MARGIN_LSB] = margin_reg;
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ceil_reg     <= `CHLC_CEIL_RESET;
			auto_th_reg  <= `CHLC_AUTO_TH_RESET;
			boost_v_reg  <= `CHLC_BOOST_V_RESET;
			boost_uv_reg <= `CHLC_BOOST_UV_RESET;
			margin_reg   <= `CHLC_MARGIN_RESET;
			rdata        <= 8'h00;
		end
		else if (clk_en_in)
		begin
			ceil_reg     <= next_ceil_reg;
			auto_th_reg  <= next_auto_th_reg;
			boost_v_reg  <= next_boost_v_reg;
			boost_uv_reg <= next_boost_uv_reg;
			margin_reg   <= next_margin_reg;
			rdata        <= next_rdata;
		end
	end

	assign reg_rdata_out = rdata;

	// ==========================================
	// write hold-off
	chlc_pkg::chlc_hold_state_t hold_state;
	chlc_pkg::chlc_hold_state_t next_hold_state;
	logic [15:0] hold_count;
	logic [15:0] next_hold_count;
	logic        apply;

	always_comb
	begin
		next_hold_state = hold_state;
		next_hold_count = hold_count;
		apply           = 1'b0;
		case (hold_state)
			chlc_pkg::CHLC_APPLIED:
			begin
				if (reg_wr_in)
				begin
					next_hold_state = chlc_pkg::CHLC_HOLDING;
					next_hold_count = 16'(HOLDOFF_CYCLES - 1);
				end
			end
			chlc_pkg::CHLC_HOLDING:
			begin
				if (reg_wr_in)
					next_hold_count = 16'(HOLDOFF_CYCLES - 1);
				else if (hold_count == 16'h0000)
				begin
					next_hold_state = chlc_pkg::CHLC_APPLIED;
					apply           = 1'b1;
				end
				else
					next_hold_count = hold_count - 16'h0001;
			end
			default:
				next_hold_state = chlc_pkg::CHLC_APPLIED;
		endcase
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			hold_state <= chlc_pkg::CHLC_APPLIED;
			hold_count <= 16'h0000;
		end
		else if (clk_en_in)
		begin
			hold_state <= next_hold_state;
			hold_count <= next_hold_count;
		end
	end

	assign holdoff_active_out = (hold_state == chlc_pkg::CHLC_HOLDING);

	// ==========================================
	// applied operating values
	logic [4:0]  act_ceil;
	logic [1:0]  act_auto_th;
	logic [1:0]  act_boost_v;
	logic [1:0]  act_boost_uv;
	logic [1:0]  act_margin;
	logic [11:0] act_ceil_ma;
	logic [12:0] trip_mv;
	logic        ovc;
	logic [4:0]  next_act_ceil;
	logic [1:0]  next_act_auto_th;
	logic [1:0]  next_act_boost_v;
	logic [1:0]  next_act_boost_uv;
	logic [1:0]  next_act_margin;
	logic [11:0] next_act_ceil_ma;
	logic [12:0] next_trip_mv;
	logic        next_ovc;

	always_comb
	begin
		next_act_ceil     = act_ceil;
		next_act_auto_th  = act_auto_th;
		next_act_boost_v  = act_boost_v;
		next_act_boost_uv = act_boost_uv;
		next_act_margin   = act_margin;
		if (apply)
		begin
			next_act_ceil     = ceil_reg;
			next_act_auto_th  = auto_th_reg;
			next_act_boost_v  = boost_v_reg;
			next_act_boost_uv = boost_uv_reg;
			next_act_margin   = margin_reg;
		end
		next_act_ceil_ma = ceiling_ma(act_ceil);
		next_trip_mv     = 13'(`CHLC_FLOAT_BASE_MV + 13'(float_voltage_code_in) * `CHLC_FLOAT_STEP_MV
		                   + margin_mv(act_margin));
		next_ovc         = (battery_mv_in >= trip_mv);
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			act_ceil     <= `CHLC_CEIL_RESET;
			act_auto_th  <= `CHLC_AUTO_TH_RESET;
			act_boost_v  <= `CHLC_BOOST_V_RESET;
			act_boost_uv <= `CHLC_BOOST_UV_RESET;
			act_margin   <= `CHLC_MARGIN_RESET;
			act_ceil_ma  <= `CHLC_CEIL_MA_RESET;
			trip_mv      <= `CHLC_TRIP_MV_RESET;
			ovc          <= 1'b0;
		end
		else if (clk_en_in)
		begin
			act_ceil     <= next_act_ceil;
			act_auto_th  <= next_act_auto_th;
			act_boost_v  <= next_act_boost_v;
			act_boost_uv <= next_act_boost_uv;
			act_margin   <= next_act_margin;
			act_ceil_ma  <= next_act_ceil_ma;
			trip_mv      <= next_trip_mv;
			ovc          <= next_ovc;
		end
	end

	assign input_current_ceiling_out        = act_ceil;
	assign input_current_ceiling_ma_out     = act_ceil_ma;
	assign auto_limit_voltage_threshold_out = act_auto_th;
	assign boost_output_voltage_sel_out     = act_boost_v;
	assign boost_undervoltage_threshold_out = act_boost_uv;
	assign overcharge_margin_sel_out        = act_margin;
	assign overcharge_trip_mv_out           = trip_mv;
	assign overcharge_detect_out            = ovc;

endmodule

// ==== hw/chlc_defines.svh ====
// offsets, field positions, reset values and timing counts of the charger limit registers
`ifndef CHLC_DEFINES_SVH
`define CHLC_DEFINES_SVH

// ==========================================
// register offsets
`define CHLC_ADDR_INPUT_LIMIT    8'h03
`define CHLC_ADDR_BOOST_OUTPUT   8'h04
`define CHLC_ADDR_OVERCHARGE     8'h05

// ==========================================
// field positions
`define CHLC_CEIL_MSB            7
`define CHLC_CEIL_LSB            3
`define CHLC_AUTO_TH_MSB         1
`define CHLC_AUTO_TH_LSB         0
`define CHLC_BOOST_V_MSB         5
`define CHLC_BOOST_V_LSB         4
`define CHLC_BOOST_UV_MSB        1
`define CHLC_BOOST_UV_LSB        0
`define CHLC_MARGIN_MSB          1
`define CHLC_MARGIN_LSB          0

// ==========================================
// reset values
`define CHLC_CEIL_RESET          5'h02
`define CHLC_AUTO_TH_RESET       2'h1
`define CHLC_BOOST_V_RESET       2'h0
`define CHLC_BOOST_UV_RESET      2'h0
`define CHLC_MARGIN_RESET        2'h2
`define CHLC_CEIL_MA_RESET       12'h1F4
`define CHLC_TRIP_MV_RESET       13'h0DE8

// ==========================================
// code to value scaling
`define CHLC_CEIL_MAX_CODE       5'h11
`define CHLC_CEIL_BASE_MA        12'h12C
`define CHLC_CEIL_STEP_MA        12'h064
`define CHLC_FLOAT_BASE_MV       13'h0D84
`define CHLC_FLOAT_STEP_MV       13'h000A
`define CHLC_MARGIN_MAX_MV       13'h00C8
`define CHLC_MARGIN_STEP_MV      13'h0032

// ==========================================
// timing
`define CHLC_CLOCK_HZ            40000000
`define CHLC_HOLDOFF_US          250
`define CHLC_HOLDOFF_CYCLES      ((`CHLC_HOLDOFF_US * (`CHLC_CLOCK_HZ / 1000000)))

`endif

// ==== hw/chlc_pkg.sv ====
// types of the charger limit registers
package chlc_pkg;

	typedef enum logic [0:0]
	{
		CHLC_APPLIED = 1'b0,
		CHLC_HOLDING = 1'b1
	} chlc_hold_state_t;

endpackage

// ==== testbench/chlc_regs_sva.sv ====
// assertion checker for the charger limit registers
`timescale 1ns/100ps
module chlc_regs_sva
#(
	parameter int HOLDOFF_CYCLES = 8
)
(
	input wire logic        clock_in,
	input wire logic        resetn_in,
	input wire logic        clk_en_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire logic [6:0]  float_voltage_code_in,
	input wire logic [12:0] battery_mv_in,
	input wire logic        holdoff_active_out,
	input wire logic [4:0]  input_current_ceiling_out,
	input wire logic [11:0] input_current_ceiling_ma_out,
	input wire logic [1:0]  overcharge_margin_sel_out,
	input wire logic [12:0] overcharge_trip_mv_out,
	input wire logic        overcharge_detect_out
);
// ==========================================
// checks
default clocking @(posedge clock_in); endclocking
default disable iff (!resetn_in);
hold_start_a: assert property (clk_en_in && reg_wr_in |=> holdoff_active_out) else $error("no hold-off");
hold_len_a: assert property ($rose(holdoff_active_out) |-> holdoff_active_out[*8]) else $error("short hold");
hold_end_a: assert property ($rose(holdoff_active_out) ##0 (clk_en_in && !reg_wr_in)[*8]
	|=> !holdoff_active_out) else $error("long hold");
hold_frozen_a: assert property (holdoff_active_out |-> $stable(overcharge_margin_sel_out)
	&& $stable(input_current_ceiling_out)) else $error("applied early");
ceil_ma_a: assert property (clk_en_in && input_current_ceiling_out <= 5'h11 |=>
	input_current_ceiling_ma_out == 12'h12C + 12'h064 * {7'h00, $past(input_current_ceiling_out)})
	else $error("bad ceiling mA");
trip_calc_a: assert property (clk_en_in |=> overcharge_trip_mv_out ==
	13'h0D84 + 13'h000A * {6'h00, $past(float_voltage_code_in)}
	+ 13'h00C8 - 13'h0032 * {11'h000, $past(overcharge_margin_sel_out)}) else $error("bad trip");
trip_detect_a: assert property (clk_en_in |=> overcharge_detect_out ==
	($past(battery_mv_in) >= $past(overcharge_trip_mv_out))) else $error("bad detect");
rd_margin_a: assert property (clk_en_in && reg_rd_in && reg_addr_in == 8'h05 && !holdoff_active_out
	|=> reg_rdata_out == {6'h00, $past(overcharge_margin_sel_out)}) else $error("bad margin read");
endmodule
bind chlc_regs chlc_regs_sva #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_sva (.*);

// ==== testbench/chlc_host_model.sv ====
// host model driving the register strobe port
`timescale 1ns/100ps
module chlc_host_model
(
	input  wire logic       clock_in,
	input  wire logic [7:0] reg_rdata_in,
	output logic      [7:0] reg_addr_out,
	output logic            reg_wr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_rd_out
);
// ==========================================
// access tasks
initial
begin
	reg_addr_out = 8'h00;
	reg_wr_out = 1'b0;
	reg_wdata_out = 8'h00;
	reg_rd_out = 1'b0;
end
task wr(input logic [7:0] a, input logic [7:0] d);
	@(posedge clock_in);
	reg_addr_out <= a;
	reg_wdata_out <= d;
	reg_wr_out <= 1'b1;
	@(posedge clock_in);
	reg_wr_out <= 1'b0;
	reg_wdata_out <= ~d;
endtask
task rd(input logic [7:0] a, output logic [7:0] d);
	@(posedge clock_in);
	reg_addr_out <= a;
	reg_rd_out <= 1'b1;
	@(posedge clock_in);
	reg_rd_out <= 1'b0;
	#1;
	d = reg_rdata_in;
endtask
task safe_margin;
	wr(8'h05, 8'h01);
endtask
endmodule

// ==== testbench/tb_chlc_regs.sv ====
// testbench for the charger limit registers
`timescale 1ns/100ps
module tb_chlc_regs;
logic        clock_in = 1'b0;
logic        resetn_in = 1'b0;
logic [7:0]  addr, wdata, rdata, d;
logic        wr, rd, hold, det;
logic        en = 1'b1;
logic [6:0]  fl = 7'h04;
logic [12:0] bat = 13'h0000, trip;
logic [4:0]  ceil;
logic [11:0] ma;
logic [1:0]  ath, bv, buv, mg;
int          fails = 0;
int          num_checks = 0;
always #12.5 clock_in = ~clock_in;
chlc_host_model u_host (.clock_in, .reg_rdata_in(rdata), .reg_addr_out(addr), .reg_wr_out(wr),
	.reg_wdata_out(wdata), .reg_rd_out(rd));
chlc_regs #(.HOLDOFF_CYCLES(8)) u_dut (.clock_in, .resetn_in, .clk_en_in(en), .reg_addr_in(addr),
	.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
	.float_voltage_code_in(fl), .battery_mv_in(bat), .holdoff_active_out(hold),
	.input_current_ceiling_out(ceil), .input_current_ceiling_ma_out(ma),
	.auto_limit_voltage_threshold_out(ath), .boost_output_voltage_sel_out(bv),
	.boost_undervoltage_threshold_out(buv), .overcharge_margin_sel_out(mg),
	.overcharge_trip_mv_out(trip), .overcharge_detect_out(det));
// ==========================================
// helpers
task chk(input logic [15:0] g, input logic [15:0] e);
	num_checks++;
	if (g !== e)
	begin
		fails++;
		$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
	end
endtask
task wait_cycles(input int n);
	repeat (n) @(posedge clock_in);
	#1;
endtask
task settle;
	repeat (40)
	begin
		@(posedge clock_in);
		#1;
		if (!hold)
			break;
	end
	wait_cycles(3);
	chk(hold, 1'b0);
endtask
task final_report;
	$display("checks %0d mismatches %0d", num_checks, fails);
	if (fails == 0 && num_checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
initial
begin
	#100000;
	fails++;
	final_report;
end
initial
begin
	repeat (12) @(posedge clock_in);
	resetn_in <= 1'b1;
	u_host.rd(8'h03, d);
	chk(d, 8'h11);
	u_host.rd(8'h04, d);
	chk(d, 8'h00);
	u_host.rd(8'h05, d);
	chk(d, 8'h02);
	chk(ma, 12'h1F4);
	$display("test 1 done");
	u_host.wr(8'h03, 8'h8B);
	u_host.wr(8'h04, 8'hFF);
	u_host.wr(8'h05, 8'hFF);
	u_host.rd(8'h04, d);
	chk(d, 8'h33);
	u_host.rd(8'h05, d);
	chk(d, 8'h03);
	u_host.rd(8'h03, d);
	chk(d, 8'h8B);
	chk(ceil, 5'h02);
	settle;
	chk(ceil, 5'h11);
	chk(ma, 12'h7D0);
	chk(ath, 2'h3);
	chk(bv, 2'h3);
	chk(buv, 2'h3);
	chk(mg, 2'h3);
	chk(trip, 13'h0DDE);
	$display("test 2 done");
	@(posedge clock_in);
	bat <= 13'h0DDE;
	wait_cycles(3);
	chk(det, 1'b1);
	@(posedge clock_in);
	bat <= 13'h0DDD;
	wait_cycles(3);
	chk(det, 1'b0);
	u_host.safe_margin();
	settle;
	chk(mg, 2'h1);
	chk(trip, 13'h0E42);
	@(posedge clock_in);
	fl <= 7'h7F;
	wait_cycles(3);
	chk(trip, 13'h1310);
	$display("test 3 done");
	u_host.rd(8'h06, d);
	chk(d, 8'h00);
	chk(hold, 1'b0);
	u_host.wr(8'h06, 8'hFF);
	#1;
	chk(hold, 1'b1);
	settle;
	u_host.rd(8'h03, d);
	chk(d, 8'h8B);
	$display("test 4 done");
	u_host.wr(8'h03, 8'hF8);
	u_host.wr(8'h05, 8'h00);
	@(posedge clock_in);
	en <= 1'b0;
	wait_cycles(12);
	chk(hold, 1'b1);
	chk(mg, 2'h1);
	@(posedge clock_in);
	en <= 1'b1;
	settle;
	chk(ceil, 5'h1F);
	chk(ma, 12'h7D0);
	chk(mg, 2'h0);
	chk(trip, 13'h1342);
	$display("test 5 done");
	resetn_in <= 1'b0;
	repeat (2) @(posedge clock_in);
	resetn_in <= 1'b1;
	u_host.rd(8'h05, d);
	chk(d, 8'h02);
	chk(mg, 2'h2);
	chk(ceil, 5'h02);
	$display("test 6 done");
	final_report;
end
endmodule
